/* File: core/pll_ctrl_pkg.sv */
// Constants for the serial control and keying logic of the synthesizer
// Functional notes
// - First rising edge, input low means write
// - Six address bits on rising edges 2-7
// - Device captures data on rising edges 8-31
// - Select rises on 32nd fall; apply word
// - Keying enabled, select low: input selects frequency
// - Select high stops keying, base frequency
// - Keying input sampled on divided reference fall
// - Data one adds offset word to fraction
// - Fraction 24 bits over two to 24th
// - Fractional only with both run bits set
// - Both run bits clear: integer only
// - Integer and fraction writes act immediately
// - Power-on reset holds defaults for 250us
// - Soft reset strobe loads defaults, timer not rerun
// - Powered down: writes work, no read out
// - Source select clear: register bit controls power
// - Read of address zero returns identifier
// - Read drives 24 bits, edges 8-31, restores lock
// - Address zero write is soft reset strobe
// - Source select resets to one, pin controls
package pll_ctrl_pkg;
  localparam logic [5:0]  ADDR_ID      = 6'h00;
  localparam logic [5:0]  ADDR_RST     = 6'h01;
  localparam logic [5:0]  ADDR_REFDIV  = 6'h02;
  localparam logic [5:0]  ADDR_INT     = 6'h03;
  localparam logic [5:0]  ADDR_FRAC    = 6'h04;
  localparam logic [5:0]  ADDR_OFFSET  = 6'h05;
  localparam logic [5:0]  ADDR_MODE    = 6'h06;
  // Power register fields
  localparam int          RST_PIN_SEL  = 0;
  localparam int          RST_SPI_EN   = 1;
  localparam int          RST_KEEP_LO  = 2;
  localparam int          RST_KEEP_HI  = 9;
  // Mode register fields, then the soft reset bit of an address zero write
  localparam int          MODE_FRAC_RUN = 0;
  localparam int          MODE_BUF_RUN  = 1;
  localparam int          MODE_FSK_EN   = 2;
  localparam int          SWRST_BIT     = 0;
  // Reset values
  localparam logic [9:0]  RST_DEFAULT    = 10'h001;
  localparam logic [13:0] REFDIV_DEFAULT = 14'h0001;
  localparam logic [15:0] INT_DEFAULT    = 16'h0024;
  localparam logic [23:0] FRAC_DEFAULT   = 24'h000000;
  localparam logic [23:0] OFFSET_DEFAULT = 24'h000000;
  localparam logic [2:0]  MODE_DEFAULT   = 3'h0;
  // Arbitrary identifier value, not a real part code
  localparam logic [23:0] ID_VALUE       = 24'h00A5C3;
  // Frame geometry
  localparam logic [5:0]  BIT_ADDR_LAST  = 6'h07;
  localparam logic [5:0]  BIT_DATA_FIRST = 6'h08;
  localparam logic [5:0]  BIT_LAST       = 6'h20;
  // Power-on reset delay
  localparam int          POR_TIME_NS    = 250000;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          POR_CYCLES     = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: core/pll_serial_control_fsk.sv */
// Serial register port, divider words and keying for the synthesizer
`timescale 1ns/1ps
module pll_serial_control_fsk #(
  parameter int POR_CYCLES = pll_ctrl_pkg::POR_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Serial pins
  input  wire logic        serial_clk_i,
  input  wire logic        serial_select_i,
  input  wire logic        serial_input_i,
  output logic             lock_or_serial_out_o,
  // Analog side
  input  wire logic        chip_enable_i,
  input  wire logic        div_ref_i,
  input  wire logic        lock_flag_i,
  output logic             por_done_o,
  output logic             power_down_o,
  output logic [7:0]       keep_on_o,
  output logic [13:0]      ref_divide_o,
  output logic [15:0]      whole_divide_o,
  output logic [23:0]      fine_numerator_o,
  output logic             frac_active_o
);
  // ==========================================
  // Reset release
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ==========================================
  // Pin synchronisers
  logic [1:0] sck_s, sel_s, din_s, ce_s, ref_s, ld_s;
  logic       sck_d, ref_d;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sck_s <= 2'b00;
      sel_s <= 2'b11;
      din_s <= 2'b00;
      ce_s  <= 2'b00;
      ref_s <= 2'b00;
      ld_s  <= 2'b00;
      sck_d <= 1'b0;
      ref_d <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], serial_clk_i};
      sel_s <= {sel_s[0], serial_select_i};
      din_s <= {din_s[0], serial_input_i};
      ce_s  <= {ce_s[0], chip_enable_i};
      ref_s <= {ref_s[0], div_ref_i};
      ld_s  <= {ld_s[0], lock_flag_i};
      sck_d <= sck_s[1];
      ref_d <= ref_s[1];
    end
  end
  wire sck_rise = sck_s[1] & ~sck_d;
  wire sck_fall = ~sck_s[1] & sck_d;
  wire ref_fall = ~ref_s[1] & ref_d;
  wire sel_low  = ~sel_s[1];
  wire din      = din_s[1];

  // ==========================================
  // Power-on reset timer
  logic [$clog2(POR_CYCLES+1)-1:0] por_cnt;
  wire por_busy = (por_cnt != POR_CYCLES[$clog2(POR_CYCLES+1)-1:0]);
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) por_cnt <= '0;
    else if (por_busy) por_cnt <= por_cnt + 1'b1;
  end

  // ==========================================
  // Serial frame
  logic [5:0]  bit_cnt;
  logic        is_read;
  logic [5:0]  addr;
  logic [23:0] shift_in;
  logic [23:0] shift_out;
  logic        sdo_active;
  logic        sdo;
  logic        pend_write;

  // Registers
  logic [9:0]  pwr_reg;
  logic [13:0] refdiv_reg;
  logic [15:0] whole_divide_ratio;
  logic [23:0] fine_step_word;
  logic [23:0] fsk_offset_word;
  logic [2:0]  mode_reg;

  wire powered_down = pwr_reg[pll_ctrl_pkg::RST_PIN_SEL] ? ~ce_s[1]
                      : ~pwr_reg[pll_ctrl_pkg::RST_SPI_EN];
  wire frame_done = sck_fall & (bit_cnt == pll_ctrl_pkg::BIT_LAST);

  logic [23:0] read_word;
  always_comb begin
    unique case (addr)
      pll_ctrl_pkg::ADDR_ID:     read_word = pll_ctrl_pkg::ID_VALUE;
      pll_ctrl_pkg::ADDR_RST:    read_word = {14'h0000, pwr_reg};
      pll_ctrl_pkg::ADDR_REFDIV: read_word = {10'h000, refdiv_reg};
      pll_ctrl_pkg::ADDR_INT:    read_word = {8'h00, whole_divide_ratio};
      pll_ctrl_pkg::ADDR_FRAC:   read_word = fine_step_word;
      pll_ctrl_pkg::ADDR_OFFSET: read_word = fsk_offset_word;
      pll_ctrl_pkg::ADDR_MODE:   read_word = {21'h000000, mode_reg};
      default:                   read_word = 24'h000000;
    endcase
  end
  wire [5:0] next_addr = {addr[4:0], din};

  // ==========================================
  // Frame phase decode; rising edge n sees the count n-1
  wire [5:0] last_rise_cnt = pll_ctrl_pkg::BIT_LAST - 6'h01;
  wire       cmd_edge  = sel_low & sck_rise & (bit_cnt == 6'h00);
  wire       addr_edge = sel_low & sck_rise & (bit_cnt != 6'h00)
                         & (bit_cnt < pll_ctrl_pkg::BIT_ADDR_LAST);
  wire       data_edge = sel_low & sck_rise & (bit_cnt >= pll_ctrl_pkg::BIT_ADDR_LAST)
                         & (bit_cnt < last_rise_cnt);
  wire       out_start = sel_low & sck_rise & (bit_cnt == pll_ctrl_pkg::BIT_ADDR_LAST)
                         & is_read & ~powered_down;
  wire       out_stop  = sel_low & sck_rise & (bit_cnt == last_rise_cnt);
  wire       out_shift = sel_low & sck_rise & sdo_active;
  // Not gated by select: the host raises it on the very fall that ends the frame
  wire       write_done = frame_done & ~is_read;

  // Bit counter
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 6'h00;
    end else if (!sel_low) begin
      bit_cnt <= 6'h00;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // Command bit
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      is_read <= 1'b0;
    end else if (cmd_edge) begin
      is_read <= din;
    end
  end

  // Address shifter
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      addr <= 6'h00;
    end else if (addr_edge) begin
      addr <= next_addr;
    end
  end

  // Data shifter
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_in <= 24'h000000;
    end else if (data_edge) begin
      shift_in <= {shift_in[22:0], din};
    end
  end

  // Read data shifter
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sdo_active <= 1'b0;
      sdo        <= 1'b0;
      shift_out  <= 24'h000000;
    end else if (!sel_low) begin
      sdo_active <= 1'b0;
    end else if (out_start) begin
      sdo_active <= 1'b1;
      sdo        <= read_word[23];
      shift_out  <= {read_word[22:0], 1'b0};
    end else if (out_stop) begin
      sdo_active <= 1'b0;
    end else if (out_shift) begin
      sdo        <= shift_out[23];
      shift_out  <= {shift_out[22:0], 1'b0};
    end
  end

  // Write strobe one cycle after the closing fall
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_write <= 1'b0;
    end else begin
      pend_write <= write_done;
    end
  end

  // ==========================================
  // Register writes
  wire soft_rst = pend_write & (addr == pll_ctrl_pkg::ADDR_ID)
                  & shift_in[pll_ctrl_pkg::SWRST_BIT];
  wire regs_clr  = por_busy | soft_rst;
  wire wr_pwr    = pend_write & (addr == pll_ctrl_pkg::ADDR_RST);
  wire wr_refdiv = pend_write & (addr == pll_ctrl_pkg::ADDR_REFDIV);
  wire wr_int    = pend_write & (addr == pll_ctrl_pkg::ADDR_INT);
  wire wr_frac   = pend_write & (addr == pll_ctrl_pkg::ADDR_FRAC);
  wire wr_offset = pend_write & (addr == pll_ctrl_pkg::ADDR_OFFSET);
  wire wr_mode   = pend_write & (addr == pll_ctrl_pkg::ADDR_MODE);

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= pll_ctrl_pkg::RST_DEFAULT;
    end else if (regs_clr) begin
      pwr_reg <= pll_ctrl_pkg::RST_DEFAULT;
    end else if (wr_pwr) begin
      pwr_reg <= shift_in[9:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      refdiv_reg <= pll_ctrl_pkg::REFDIV_DEFAULT;
    end else if (regs_clr) begin
      refdiv_reg <= pll_ctrl_pkg::REFDIV_DEFAULT;
    end else if (wr_refdiv) begin
      refdiv_reg <= shift_in[13:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      whole_divide_ratio <= pll_ctrl_pkg::INT_DEFAULT;
    end else if (regs_clr) begin
      whole_divide_ratio <= pll_ctrl_pkg::INT_DEFAULT;
    end else if (wr_int) begin
      whole_divide_ratio <= shift_in[15:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      fine_step_word <= pll_ctrl_pkg::FRAC_DEFAULT;
    end else if (regs_clr) begin
      fine_step_word <= pll_ctrl_pkg::FRAC_DEFAULT;
    end else if (wr_frac) begin
      fine_step_word <= shift_in;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      fsk_offset_word <= pll_ctrl_pkg::OFFSET_DEFAULT;
    end else if (regs_clr) begin
      fsk_offset_word <= pll_ctrl_pkg::OFFSET_DEFAULT;
    end else if (wr_offset) begin
      fsk_offset_word <= shift_in;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= pll_ctrl_pkg::MODE_DEFAULT;
    end else if (regs_clr) begin
      mode_reg <= pll_ctrl_pkg::MODE_DEFAULT;
    end else if (wr_mode) begin
      mode_reg <= shift_in[2:0];
    end
  end

  // ==========================================
  // Keying and divider outputs
  logic key_bit;
  wire  frac_on = mode_reg[pll_ctrl_pkg::MODE_FRAC_RUN]
                  & mode_reg[pll_ctrl_pkg::MODE_BUF_RUN];
  wire  keying  = mode_reg[pll_ctrl_pkg::MODE_FSK_EN] & sel_low;
  wire [23:0] next_num = !frac_on ? 24'h000000
                       : (keying & key_bit) ? fine_step_word + fsk_offset_word
                       : fine_step_word;

  // Keying level, taken on the divided reference fall
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      key_bit <= 1'b0;
    end else if (!keying) begin
      key_bit <= 1'b0;
    end else if (ref_fall) begin
      key_bit <= din;
    end
  end

  // Shared pin: lock flag outside read data
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_or_serial_out_o <= 1'b0;
    end else begin
      lock_or_serial_out_o <= sdo_active ? sdo : ld_s[1];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      por_done_o <= 1'b0;
    end else begin
      por_done_o <= ~por_busy;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      power_down_o <= 1'b0;
    end else begin
      power_down_o <= powered_down;
    end
  end

  // Register copies toward the analog side
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      keep_on_o      <= 8'h00;
      ref_divide_o   <= pll_ctrl_pkg::REFDIV_DEFAULT;
      whole_divide_o <= pll_ctrl_pkg::INT_DEFAULT;
    end else begin
      keep_on_o      <= pwr_reg[pll_ctrl_pkg::RST_KEEP_HI:pll_ctrl_pkg::RST_KEEP_LO];
      ref_divide_o   <= refdiv_reg;
      whole_divide_o <= whole_divide_ratio;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      fine_numerator_o <= 24'h000000;
    end else begin
      fine_numerator_o <= next_num;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      frac_active_o <= 1'b0;
    end else begin
      frac_active_o <= frac_on;
    end
  end
endmodule

/* File: sim/pll_serial_control_fsk_checker.sv */
// Port-level assertions for the serial control and keying block
`timescale 1ns/1ps
module pll_serial_control_fsk_checker #(
  parameter int POR_CYCLES = 20
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        serial_select_i,
  input wire logic        chip_enable_i,
  input wire logic        lock_flag_i,
  input wire logic        lock_or_serial_out_o,
  input wire logic        por_done_o,
  input wire logic        power_down_o,
  input wire logic [7:0]  keep_on_o,
  input wire logic [13:0] ref_divide_o,
  input wire logic [15:0] whole_divide_o,
  input wire logic [23:0] fine_numerator_o,
  input wire logic        frac_active_o
);
  int cnt;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles since reset release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt <= 0;
    else cnt <= cnt + 1;
  end
  sequence idle_s;
    serial_select_i [*8];
  endsequence
  reset_vals_a: assert property ($rose(rst_n_i) |-> whole_divide_o == 16'h0024 && ref_divide_o == 14'h0001)
    else $error("defaults missing after reset");
  por_defaults_a: assert property (!por_done_o |-> whole_divide_o == 16'h0024 && keep_on_o == 8'h00)
    else $error("register left default before timer end");
  por_sticky_a: assert property (por_done_o |=> por_done_o)
    else $error("timer done flag dropped");
  por_time_a: assert property ($rose(por_done_o) |-> cnt >= POR_CYCLES && cnt <= POR_CYCLES + 6)
    else $error("timer done at wrong cycle");
  frac_off_a: assert property (!frac_active_o [*2] |-> fine_numerator_o == 24'h000000)
    else $error("fraction used in integer mode");
  lock_idle_a: assert property ((serial_select_i && $stable(lock_flag_i)) [*6] |-> lock_or_serial_out_o == lock_flag_i)
    else $error("lock flag not shown outside frames");
  words_hold_a: assert property (idle_s |-> $stable(whole_divide_o) && $stable(fine_numerator_o))
    else $error("divider word moved without a frame");
  pin_power_a: assert property ((!por_done_o && $stable(chip_enable_i)) [*6] |-> power_down_o == !chip_enable_i)
    else $error("power down not following pin");
endmodule
bind pll_serial_control_fsk pll_serial_control_fsk_checker #(.POR_CYCLES(POR_CYCLES)) i_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .serial_select_i(serial_select_i),
  .chip_enable_i(chip_enable_i), .lock_flag_i(lock_flag_i), .por_done_o(por_done_o),
  .lock_or_serial_out_o(lock_or_serial_out_o), .power_down_o(power_down_o),
  .keep_on_o(keep_on_o), .ref_divide_o(ref_divide_o), .whole_divide_o(whole_divide_o),
  .fine_numerator_o(fine_numerator_o), .frac_active_o(frac_active_o)
);

/* File: sim/pll_serial_control_fsk_tb.sv */
// Self-checking bench for the serial control and keying block
`timescale 1ns/1ps
module pll_serial_control_fsk_tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        chip_enable_i = 1'b1;
  logic        div_ref_i = 1'b0;
  logic        lock_flag_i = 1'b1;
  logic        sck, sel, din, sdo, por_done, pdn, fact;
  logic [7:0]  keep_on;
  logic [13:0] refdiv;
  logic [15:0] whole;
  logic [23:0] fine, q;
  int          fails = 0;
  int          n_compared = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  serial_host_model i_host (.clk_sys_i(clk_sys_i), .lock_or_serial_out_o(sdo),
    .sck_o(sck), .sel_o(sel), .din_o(din));
  pll_serial_control_fsk #(.POR_CYCLES(20)) i_dut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .serial_clk_i(sck), .serial_select_i(sel), .serial_input_i(din),
    .lock_or_serial_out_o(sdo), .chip_enable_i(chip_enable_i), .div_ref_i(div_ref_i),
    .lock_flag_i(lock_flag_i), .por_done_o(por_done), .power_down_o(pdn),
    .keep_on_o(keep_on), .ref_divide_o(refdiv), .whole_divide_o(whole),
    .fine_numerator_o(fine), .frac_active_o(fact));
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    i_host.frame(1'b0, a, d, 32, q);
  endtask
  // Keying level held while the divided reference falls twice
  task automatic key(input logic d);
    i_host.level(1'b0, d);
    repeat (2) begin
      repeat (8) @(posedge clk_sys_i);
      div_ref_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      div_ref_i <= 1'b0;
    end
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic wrap_up;
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 200 && !por_done; i++) @(posedge clk_sys_i);
    check("por", {23'h0, por_done}, 24'h000001);
    i_host.frame(1'b1, 6'h00, 24'h0, 32, q);
    check("id", q, pll_ctrl_pkg::ID_VALUE);
    wr(6'h03, 24'h001234);
    check("whole", {8'h0, whole}, 24'h001234);
    i_host.frame(1'b0, 6'h03, 24'h000FFF, 10, q);
    i_host.frame(1'b1, 6'h03, 24'h0, 32, q);
    check("abort", q, 24'h001234);
    wr(6'h04, 24'h000100);
    wr(6'h05, 24'h000010);
    check("int mode", fine, 24'h000000);
    wr(6'h06, 24'h000001);
    check("mixed", {23'h0, fact}, 24'h000000);
    wr(6'h06, 24'h000007);
    check("frac", fine, 24'h000100);
    key(1'b1);
    check("key1", fine, 24'h000110);
    key(1'b0);
    check("key0", fine, 24'h000100);
    key(1'b1);
    i_host.level(1'b1, 1'b1);
    repeat (8) @(posedge clk_sys_i);
    check("key off", fine, 24'h000100);
    wr(6'h01, 24'h0003FC);
    check("pdn", {15'h0, pdn, keep_on}, 24'h0001FF);
    i_host.frame(1'b1, 6'h00, 24'h0, 32, q);
    check("pdn rd", q, 24'hFFFFFF);
    wr(6'h03, 24'h000080);
    check("pdn wr", {8'h0, whole}, 24'h000080);
    wr(6'h01, 24'h000002);
    check("spi on", {23'h0, pdn}, 24'h000000);
    wr(6'h02, 24'h000005);
    check("refdiv", {10'h0, refdiv}, 24'h000005);
    wr(6'h00, 24'h000001);
    check("swrst", {7'h0, pdn, whole}, 24'h000024);
    check("swrst ref", {10'h0, refdiv}, 24'h000001);
    chip_enable_i <= 1'b0;
    i_host.frame(1'b1, 6'h00, 24'h0, 32, q);
    check("pin pdn", {pdn, q[22:0]}, 24'hFFFFFF);
    chip_enable_i <= 1'b1;
    i_host.frame(1'b1, 6'h3F, 24'h0, 32, q);
    check("unmapped", q, 24'h000000);
    wr(6'h05, 24'h000000);
    wr(6'h04, 24'h000000);
    wr(6'h03, 24'h0000A4);
    check("interim", {8'h0, whole}, 24'h0000A4);
    wr(6'h03, 24'h000080);
    check("final int", {8'h0, whole}, 24'h000080);
    wr(6'h05, 24'h000200);
    wr(6'h04, 24'h000300);
    i_host.frame(1'b1, 6'h04, 24'h0, 32, q);
    check("final frac", q, 24'h000300);
    wrap_up;
  end
endmodule

/* File: sim/serial_host_model.sv */
// Host model driving the serial control port
`timescale 1ns/1ps
module serial_host_model (
  // Clock and serial pins
  input  wire logic clk_sys_i,
  input  wire logic lock_or_serial_out_o,
  output logic      sck_o,
  output logic      sel_o,
  output logic      din_o
);
  initial begin
    sck_o = 1'b0;
    sel_o = 1'b1;
    din_o = 1'b0;
  end
  // Select and keying level, serial clock left still
  task automatic level(input logic sel, input logic d);
    @(posedge clk_sys_i);
    sel_o <= sel;
    din_o <= d;
  endtask
  // Frame of nbits clocks, 80 ns each; fewer than 32 aborts it
  task automatic frame(input logic rw, input logic [5:0] a, input logic [23:0] d,
                       input int nbits, output logic [23:0] q);
    logic [30:0] w;
    w = {rw, a, d};
    q = 24'h000000;
    @(posedge clk_sys_i);
    sel_o <= 1'b0;
    din_o <= w[30];
    for (int i = 0; i < nbits; i++) begin
      repeat (10) @(posedge clk_sys_i);
      sck_o <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      if (i >= 7 && i <= 30) q = {q[22:0], lock_or_serial_out_o};
      sck_o <= 1'b0;
      if (i < 30) din_o <= w[29 - i];
      if (i == nbits - 1) sel_o <= 1'b1;
    end
    // Released data line shows the inverse of its last level
    @(posedge clk_sys_i);
    din_o <= ~din_o;
    repeat (160) @(posedge clk_sys_i);
  endtask
endmodule
